// [core/alu_slice_pkg.sv]
package alu_slice_pkg;

	////////////////////////////////////////////////////////////////////////////
	// instruction word layout
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int OPC_MSB = 13;
	localparam int OPC6_LSB = 8;
	localparam int OPC5_LSB = 9;
	localparam int DEST_BIT = 7;
	localparam int LIT_MSB = 7;
	localparam int NIB_W = 4;

	////////////////////////////////////////////////////////////////////////////
	// opcode patterns (upper six bits, or upper five where bit 8 is don't care)
	localparam logic [5:0] OPC_NIBBLE_SWAP = 6'h0e;
	localparam logic [5:0] OPC_XOR_LITERAL = 6'h3a;
	localparam logic [5:0] OPC_SUB_FROM_FILE = 6'h02;
	localparam logic [4:0] OPC_SUB_FROM_LITERAL = 5'h1e;

	// destination bit values
	localparam logic DEST_W = 1'h0;
	localparam logic DEST_FILE = 1'h1;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_W = 8'h00;
	localparam logic RST_CARRY = 1'h0;
	localparam logic RST_DIGIT_CARRY = 1'h0;
	localparam logic RST_ZERO = 1'h0;
	localparam logic [6:0] RST_FILE_ADDR = 7'h00;
	localparam logic [7:0] RST_FILE_DATA = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// decoded operation, one-hot
	typedef enum logic [4:0] {
		OP_NONE = 5'h01,
		OP_NIBBLE_SWAP = 5'h02,
		OP_XOR_LITERAL = 5'h04,
		OP_SUB_FROM_LITERAL = 5'h08,
		OP_SUB_FROM_FILE = 5'h10
	} op_t;

	// status flags kept by this slice
	typedef struct packed {
		logic carry;
		logic digit_carry;
		logic zero;
	} flags_t;

	// write toward the register file
	typedef struct packed {
		logic we;
		logic [6:0] addr;
		logic [7:0] data;
	} file_wr_t;

	// outcome of a subtraction
	typedef struct packed {
		logic [7:0] diff;
		logic carry;
		logic digit_carry;
	} sub_res_t;

	// all state of the slice
	typedef struct packed {
		logic [7:0] w;
		flags_t flags;
		file_wr_t file_wr;
		logic done;
		logic unknown;
	} alu_state_t;

endpackage

// [core/alu_slice.sv]
`timescale 1ns/1ps
// What this block does
// - nibble swap exchanges high and low nibbles of file register, flags untouched
// - nibble swap result goes to W if destination bit 0, else file
// - literal XOR combines W with low eight instruction bits, result into W
// - subtract with negative difference clears carry; stored result wraps modulo 256
// - subtract with zero or positive difference sets carry
module alu_slice
	import alu_slice_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_exec,
	input wire logic [INSTR_W-1:0] i_instr,
	input wire logic [DATA_W-1:0] i_file_rdata,
	output logic [DATA_W-1:0] o_w,
	output logic o_carry,
	output logic o_digit_carry,
	output logic o_zero,
	output logic o_file_we,
	output logic [FADDR_W-1:0] o_file_waddr,
	output logic [DATA_W-1:0] o_file_wdata,
	output logic o_done,
	output logic o_unknown
);

	////////////////////////////////////////////////////////////////////////////
	// decoding helpers

	// the same opcode decode serves the datapath and the done/unknown flags
	function automatic op_t decode_op(input logic [INSTR_W-1:0] instr);
		op_t op;
		op = OP_NONE;
		if (instr[OPC_MSB:OPC6_LSB] == OPC_NIBBLE_SWAP) begin
			op = OP_NIBBLE_SWAP;
		end else if (instr[OPC_MSB:OPC6_LSB] == OPC_XOR_LITERAL) begin
			op = OP_XOR_LITERAL;
		end else if (instr[OPC_MSB:OPC5_LSB] == OPC_SUB_FROM_LITERAL) begin
			op = OP_SUB_FROM_LITERAL;
		end else if (instr[OPC_MSB:OPC6_LSB] == OPC_SUB_FROM_FILE) begin
			op = OP_SUB_FROM_FILE;
		end
		return op;
	endfunction

	function automatic logic [DATA_W-1:0] swap_nibbles(input logic [DATA_W-1:0] v);
		return {v[NIB_W-1:0], v[DATA_W-1:NIB_W]};
	endfunction

	// minuend minus subtrahend; borrow out of the ninth bit means negative
	function automatic sub_res_t subtract(input logic [DATA_W-1:0] minuend,
			input logic [DATA_W-1:0] subtrahend);
		sub_res_t r;
		logic [DATA_W:0] wide;
		logic [NIB_W:0] low;
		wide = {1'b0, minuend} - {1'b0, subtrahend};
		low = {1'b0, minuend[NIB_W-1:0]} - {1'b0, subtrahend[NIB_W-1:0]};
		r.diff = wide[DATA_W-1:0];
		r.carry = ~wide[DATA_W];
		r.digit_carry = ~low[NIB_W];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	alu_state_t state;
	alu_state_t next_state;

	op_t op;
	logic dest_file;
	logic [FADDR_W-1:0] faddr;
	logic [DATA_W-1:0] literal;
	logic [DATA_W-1:0] swapped;
	logic [DATA_W-1:0] xored;
	sub_res_t sub_lit;
	sub_res_t sub_file;

	assign op = decode_op(i_instr);
	assign dest_file = i_instr[DEST_BIT];
	assign faddr = i_instr[FADDR_W-1:0];
	assign literal = i_instr[LIT_MSB:0];
	assign swapped = swap_nibbles(i_file_rdata);
	assign xored = state.w ^ literal;
	assign sub_lit = subtract(literal, state.w);
	assign sub_file = subtract(i_file_rdata, state.w);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state = state;
		// file write, done and unknown are one-cycle pulses
		next_state.file_wr.we = 1'b0;
		next_state.done = 1'b0;
		next_state.unknown = 1'b0;
		if (i_exec) begin
			// every operation retires in the single cycle after i_exec
			next_state.done = (op != OP_NONE);
			case (op)
				OP_NIBBLE_SWAP: begin
					// flags deliberately left alone here
					if (dest_file == DEST_W) begin
						next_state.w = swapped;
					end else begin
						next_state.file_wr.we = 1'b1;
						next_state.file_wr.addr = faddr;
						next_state.file_wr.data = swapped;
					end
				end
				OP_XOR_LITERAL: begin
					next_state.w = xored;
					next_state.flags.zero = (xored == 8'h00);
				end
				OP_SUB_FROM_LITERAL: begin
					next_state.w = sub_lit.diff;
					next_state.flags.carry = sub_lit.carry;
					next_state.flags.digit_carry = sub_lit.digit_carry;
					next_state.flags.zero = (sub_lit.diff == 8'h00);
				end
				OP_SUB_FROM_FILE: begin
					if (dest_file == DEST_W) begin
						next_state.w = sub_file.diff;
					end else begin
						next_state.file_wr.we = 1'b1;
						next_state.file_wr.addr = faddr;
						next_state.file_wr.data = sub_file.diff;
					end
					next_state.flags.carry = sub_file.carry;
					next_state.flags.digit_carry = sub_file.digit_carry;
					next_state.flags.zero = (sub_file.diff == 8'h00);
				end
				OP_NONE: begin
					// other instructions belong to other slices; just report
					next_state.unknown = 1'b1;
				end
				default: begin
					next_state.unknown = 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state.w <= RST_W;
			state.flags.carry <= RST_CARRY;
			state.flags.digit_carry <= RST_DIGIT_CARRY;
			state.flags.zero <= RST_ZERO;
			state.file_wr.we <= 1'b0;
			state.file_wr.addr <= RST_FILE_ADDR;
			state.file_wr.data <= RST_FILE_DATA;
			state.done <= 1'b0;
			state.unknown <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flip-flops

	assign o_w = state.w;
	assign o_carry = state.flags.carry;
	assign o_digit_carry = state.flags.digit_carry;
	assign o_zero = state.flags.zero;
	assign o_file_we = state.file_wr.we;
	assign o_file_waddr = state.file_wr.addr;
	assign o_file_wdata = state.file_wr.data;
	assign o_done = state.done;
	assign o_unknown = state.unknown;

endmodule

// [bench/file_model.sv]
`timescale 1ns/1ps
module file_model (
	input wire logic i_sys_clk,
	input wire logic [6:0] i_raddr,
	input wire logic i_we,
	input wire logic [6:0] i_waddr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [128] = '{default: 8'h00};
	// read is combinational, same cycle as the slice expects
	assign o_rdata = mem[i_raddr];
	always @(posedge i_sys_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end
endmodule

// [bench/alu_slice_props.sv]
`timescale 1ns/1ps
module alu_slice_props (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_exec,
	input wire logic [13:0] i_instr,
	input wire logic [7:0] i_file_rdata,
	input wire logic [7:0] o_w,
	input wire logic o_carry,
	input wire logic o_digit_carry,
	input wire logic o_zero,
	input wire logic o_file_we,
	input wire logic [6:0] o_file_waddr,
	input wire logic [7:0] o_file_wdata,
	input wire logic o_done
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_swap;
		i_exec && i_instr[13:8] == 6'h0e;
	endsequence
	sequence s_subl;
		i_exec && i_instr[13:9] == 5'h1e;
	endsequence
	property p_swap_file;
		s_swap ##0 i_instr[7] |=> o_file_we && o_file_waddr == $past(i_instr[6:0])
			&& {o_file_wdata[3:0], o_file_wdata[7:4]} == $past(i_file_rdata);
	endproperty
	a_swap_file: assert property (p_swap_file) else $error("swap to file");
	property p_swap_w;
		s_swap ##0 !i_instr[7] |=> !o_file_we && {o_w[3:0], o_w[7:4]} == $past(i_file_rdata);
	endproperty
	a_swap_w: assert property (p_swap_w) else $error("swap to w");
	property p_swap_flags;
		s_swap |=> $stable({o_carry, o_digit_carry, o_zero});
	endproperty
	a_swap_flags: assert property (p_swap_flags) else $error("swap flags");
	property p_xor;
		i_exec && i_instr[13:8] == 6'h3a |=> o_done && (o_w ^ $past(o_w)) == $past(i_instr[7:0])
			&& o_zero == (o_w == 8'h00);
	endproperty
	a_xor: assert property (p_xor) else $error("xor literal");
	property p_subl;
		s_subl |=> o_carry == ($past(o_w) <= $past(i_instr[7:0]))
			&& 8'(o_w + $past(o_w)) == $past(i_instr[7:0]);
	endproperty
	a_subl: assert property (p_subl) else $error("sub literal");
	property p_subf;
		i_exec && i_instr[13:8] == 6'h02 |=> o_carry == ($past(o_w) <= $past(i_file_rdata));
	endproperty
	a_subf: assert property (p_subf) else $error("sub file");
endmodule
bind alu_slice alu_slice_props props_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_exec(i_exec), .i_instr(i_instr), .i_file_rdata(i_file_rdata), .o_w(o_w),
	.o_carry(o_carry), .o_digit_carry(o_digit_carry), .o_zero(o_zero),
	.o_file_we(o_file_we), .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata),
	.o_done(o_done));

// [bench/tb_alu_slice.sv]
`timescale 1ns/1ps
module tb_alu_slice;
	import alu_slice_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic ex = 1'h0;
	logic [INSTR_W-1:0] ins = 14'h0000;
	logic [7:0] rd, w, wd;
	logic [6:0] wa;
	logic c, dc, z, we, done, unk;
	int n_errors = 0;
	int n_tests = 0;
	always #10 clk = ~clk;
	alu_slice dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_exec(ex), .i_instr(ins),
		.i_file_rdata(rd), .o_w(w), .o_carry(c), .o_digit_carry(dc), .o_zero(z),
		.o_file_we(we), .o_file_waddr(wa), .o_file_wdata(wd), .o_done(done),
		.o_unknown(unk));
	file_model rf_u (.i_sys_clk(clk), .i_raddr(ins[6:0]), .i_we(we), .i_waddr(wa),
		.i_wdata(wd), .o_rdata(rd));
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic run(input logic [13:0] i);
		@(negedge clk);
		ex = 1'h1;
		ins = i;
		@(negedge clk);
		ex = 1'h0;
	endtask
	task automatic t_sub();
		for (int k = 1; k < 4; k++) begin
			run({6'h3a, w ^ 8'(k)});
			run(14'h3c02);
			check(w, 8'(2 - k));
			check({7'h00, c}, {7'h00, k < 3});
			run({6'h3a, w ^ 8'(k)});
			rf_u.mem[9] = 8'h02;
			run(14'h0289);
			check(wd, 8'(2 - k));
			check({7'h00, c}, {7'h00, k < 3});
		end
	endtask
	task automatic t_swap();
		// zero difference first, so all three flags stand set across the swap
		run({6'h3a, w ^ 8'h02});
		run(14'h3c02);
		check({5'h00, c, dc, z}, 8'h07);
		rf_u.mem[5] = 8'ha5;
		run(14'h0e05);
		check(w, 8'h5a);
		check({5'h00, c, dc, z}, 8'h07);
		run(14'h0e85);
		check({we, wa}, 8'h85);
		check(w, 8'h5a);
		check(wd, 8'h5a);
	endtask
	task automatic t_xor();
		// back to back: second xor must see the forwarded w
		@(negedge clk);
		ex = 1'h1;
		ins = 14'h3a5a;
		@(negedge clk);
		check({7'h00, z}, 8'h01);
		ins = 14'h3aaf;
		@(negedge clk);
		ex = 1'h0;
		check(w, 8'haf);
		check({6'h00, z, done}, 8'h01);
		// zero was clear, so this one proves the set
		run(14'h3aaf);
		check({7'h00, z}, 8'h01);
		run(14'h0000);
		check({6'h00, unk, done}, 8'h02);
	endtask
	task automatic print_verdict();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100us;
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'h1;
		t_sub();
		t_swap();
		t_xor();
		print_verdict();
	end
endmodule
